// *** tsc_pkg.sv ***
`default_nettype none
package tsc_pkg;
	localparam logic [7:0] TSC_ADDR_CTRL = 8'h0e;
	localparam logic [7:0] TSC_ADDR_CFG = 8'h0f;
	localparam logic [7:0] TSC_ADDR_RELOAD_HI = 8'h10;
	localparam logic [7:0] TSC_ADDR_RELOAD_LO = 8'h11;
	localparam logic [7:0] TSC_ADDR_COUNT_HI = 8'h12;
	localparam logic [7:0] TSC_ADDR_COUNT_LO = 8'h13;
	localparam logic [7:0] TSC_ADDR_IRQ_STATUS = 8'h40;
	localparam logic [7:0] TSC_ADDR_IRQ_CLEAR = 8'h41;
	localparam logic [7:0] TSC_ADDR_IRQ_ENABLE = 8'h42;
	localparam int TSC_CTRL_RUN_LSB = 4;
	localparam int TSC_NUM_TIMERS = 4;
	localparam int TSC_IRQ_UNDERFLOW = 0;
	localparam int TSC_IRQ_RX_HALT = 1;
	localparam int TSC_IRQ_STOPPED = 2;
	localparam int TSC_IRQ_BITS = 3;
	localparam logic [7:0] TSC_CFG_RESET = 8'h00;
	localparam logic [7:0] TSC_RELOAD_RESET = 8'h00;
	localparam logic [15:0] TSC_COUNT_RESET = 16'h0000;
	localparam logic [2:0] TSC_IRQ_RESET = 3'h0;
	localparam logic [7:0] TSC_BYTE_ZERO = 8'h00;

	typedef enum logic [1:0] {
		TSC_START_MANUAL = 2'h0,
		TSC_START_TX_END = 2'h1,
		TSC_START_TRIM_NO_UF = 2'h2,
		TSC_START_TRIM_UF = 2'h3
	} tsc_start_mode_type;

	typedef enum logic [1:0] {
		TSC_CLK_FAST = 2'h0,
		TSC_CLK_SLOW = 2'h1,
		TSC_CLK_TIMER2 = 2'h2,
		TSC_CLK_TIMER1 = 2'h3
	} tsc_clock_select_type;

	// Field order matches the register bit layout
	typedef struct packed {
		logic timer0_halt_on_receive;
		logic rsv6;
		tsc_start_mode_type timer0_start_mode;
		logic timer0_reload_on_zero;
		logic rsv2;
		tsc_clock_select_type timer0_clock_select;
	} tsc_cfg_type;

	typedef struct packed {
		logic tick_fast;
		logic tick_slow;
		logic timer1_underflow;
		logic timer2_underflow;
	} tsc_ticks_type;
endpackage : tsc_pkg
`default_nettype wire

// *** tsc_timer_section.sv ***
// The address-and-strobe port was decided locally.
`timescale 1ns/10ps
`default_nettype none
module tsc_timer_section
	import tsc_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// Count sources, same clock domain, one-cycle pulses
	input wire tsc_ticks_type ticks,
	// Transceiver events, same clock domain, one-cycle pulses
	input wire logic tx_end,
	input wire logic rx_first_bits,
	// Oscillator trimming reference, asynchronous pin
	input wire logic low_freq_oscillator,
	// Timers 1 to 3 report their own stop, one-cycle pulses
	input wire logic [3:1] other_timer_stopped,
	// Status toward the other timers and the system
	output logic [3:0] timer_running,
	output logic timer0_underflow,
	output logic irq
);
	logic [3:1] other_active_flag;
	logic timer0_active_flag;
	tsc_cfg_type cfg;
	logic [7:0] timer0_reload_upper;
	logic [7:0] timer0_reload_lower;
	logic [15:0] timer0_count;
	logic [TSC_IRQ_BITS-1:0] irq_status;
	logic [TSC_IRQ_BITS-1:0] irq_enable;
	logic lfo_s1;
	logic lfo_s2;
	logic lfo_s3;

	logic ctrl_wr;
	logic sw_touch;
	logic sw_start;
	logic [15:0] timer0_reload_word;
	logic tick_sel;
	logic tick_active;
	logic at_zero;
	logic trim_mode;
	logic lfo_rise;
	logic underflow_evt;
	logic stop_rx;
	logic stop_trim;
	logic stop_uf;
	logic restart_uf;
	logic start_evt;
	logic stop_evt;
	logic load_evt;
	logic [TSC_IRQ_BITS-1:0] irq_set;
	logic [TSC_IRQ_BITS-1:0] irq_clr;
	logic [7:0] next_rdata;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	assign ctrl_wr = reg_wr && (reg_addr == TSC_ADDR_CTRL);
	assign sw_touch = ctrl_wr && reg_wdata[0];
	assign sw_start = sw_touch && reg_wdata[TSC_CTRL_RUN_LSB];
	assign timer0_reload_word = {timer0_reload_upper, timer0_reload_lower};
	assign trim_mode = cfg.timer0_start_mode[1];
	assign lfo_rise = lfo_s2 && !lfo_s3;

	// Count source for timer 0
	always_comb begin
		unique case (cfg.timer0_clock_select)
			TSC_CLK_FAST: tick_sel = ticks.tick_fast;
			TSC_CLK_SLOW: tick_sel = ticks.tick_slow;
			TSC_CLK_TIMER2: tick_sel = ticks.timer2_underflow;
			TSC_CLK_TIMER1: tick_sel = ticks.timer1_underflow;
		endcase
	end

	assign tick_active = timer0_active_flag && tick_sel;
	assign at_zero = (timer0_count == TSC_COUNT_RESET);
	// Trimming without underflow parks at zero and raises no underflow event
	assign underflow_evt = tick_active && at_zero && (cfg.timer0_start_mode != TSC_START_TRIM_NO_UF);
	assign stop_uf = underflow_evt && !cfg.timer0_reload_on_zero;
	assign restart_uf = underflow_evt && cfg.timer0_reload_on_zero;
	assign stop_rx = timer0_active_flag && rx_first_bits && cfg.timer0_halt_on_receive && !trim_mode;
	assign stop_trim = timer0_active_flag && trim_mode && lfo_rise;
	assign start_evt = !timer0_active_flag && (((cfg.timer0_start_mode == TSC_START_TX_END) && tx_end)
		|| (trim_mode && lfo_rise));
	assign stop_evt = stop_rx || stop_trim || stop_uf;
	assign load_evt = sw_start || (!sw_touch && (start_evt || restart_uf));

	// Two-stage synchroniser; the edge detector looks only past the second stage
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			lfo_s1 <= 1'b0;
			lfo_s2 <= 1'b0;
			lfo_s3 <= 1'b0;
		end else begin
			lfo_s1 <= low_freq_oscillator;
			lfo_s2 <= lfo_s1;
			lfo_s3 <= lfo_s2;
		end
	end

	// Software write wins over hardware start and stop in the same cycle
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			timer0_active_flag <= 1'b0;
		end else if (sw_touch) begin
			timer0_active_flag <= reg_wdata[TSC_CTRL_RUN_LSB];
		end else if (stop_evt) begin
			timer0_active_flag <= 1'b0;
		end else if (start_evt) begin
			timer0_active_flag <= 1'b1;
		end
	end

	generate
		for (genvar i = 1; i < TSC_NUM_TIMERS; i++) begin : g_other
			always_ff @(posedge clk) begin
				if (!rst_n) begin
					other_active_flag[i] <= 1'b0;
				end else if (ctrl_wr && reg_wdata[i]) begin
					other_active_flag[i] <= reg_wdata[TSC_CTRL_RUN_LSB+i];
				end else if (other_timer_stopped[i]) begin
					other_active_flag[i] <= 1'b0;
				end
			end
		end
	endgenerate

	// Reload bytes only reach the counter through load_evt
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			timer0_count <= TSC_COUNT_RESET;
		end else if (load_evt) begin
			timer0_count <= timer0_reload_word;
		end else if (tick_active && !at_zero) begin
			timer0_count <= timer0_count - 16'h0001;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cfg <= TSC_CFG_RESET;
			timer0_reload_upper <= TSC_RELOAD_RESET;
			timer0_reload_lower <= TSC_RELOAD_RESET;
			irq_enable <= TSC_IRQ_RESET;
		end else if (reg_wr) begin
			unique case (reg_addr)
				TSC_ADDR_CFG: begin
					cfg <= reg_wdata;
					cfg.rsv6 <= 1'b0;
					cfg.rsv2 <= 1'b0;
				end
				TSC_ADDR_RELOAD_HI: timer0_reload_upper <= reg_wdata;
				TSC_ADDR_RELOAD_LO: timer0_reload_lower <= reg_wdata;
				TSC_ADDR_IRQ_ENABLE: irq_enable <= reg_wdata[TSC_IRQ_BITS-1:0];
				default: begin
				end
			endcase
		end
	end

	assign irq_set = {stop_evt && timer0_active_flag && !sw_touch, stop_rx, underflow_evt};
	assign irq_clr = (reg_wr && (reg_addr == TSC_ADDR_IRQ_CLEAR)) ? reg_wdata[TSC_IRQ_BITS-1:0] : TSC_IRQ_RESET;

	// Set beats clear so an event in the clearing cycle is kept
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			irq_status <= TSC_IRQ_RESET;
		end else begin
			irq_status <= (irq_status & ~irq_clr) | irq_set;
		end
	end

	// Output is registered, so it follows an enable write one cycle late
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			irq <= 1'b0;
			timer0_underflow <= 1'b0;
		end else begin
			irq <= |((irq_status & ~irq_clr | irq_set) & irq_enable);
			timer0_underflow <= underflow_evt;
		end
	end

	assign timer_running = {other_active_flag, timer0_active_flag};

	always_comb begin
		next_rdata = TSC_BYTE_ZERO;
		unique case (reg_addr)
			TSC_ADDR_CTRL: next_rdata = {other_active_flag, timer0_active_flag, 4'h0};
			TSC_ADDR_CFG: next_rdata = {cfg.timer0_halt_on_receive, 1'b0, cfg.timer0_start_mode,
				cfg.timer0_reload_on_zero, 1'b0, cfg.timer0_clock_select};
			TSC_ADDR_RELOAD_HI: next_rdata = timer0_reload_upper;
			TSC_ADDR_RELOAD_LO: next_rdata = timer0_reload_lower;
			// Two reads of a running count are not atomic; read while stopped
			TSC_ADDR_COUNT_HI: next_rdata = timer0_count[15:8];
			TSC_ADDR_COUNT_LO: next_rdata = timer0_count[7:0];
			TSC_ADDR_IRQ_STATUS: next_rdata = {5'h00, irq_status};
			TSC_ADDR_IRQ_ENABLE: next_rdata = {5'h00, irq_enable};
			default: next_rdata = TSC_BYTE_ZERO;
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			reg_rdata <= TSC_BYTE_ZERO;
		end else if (reg_rd) begin
			reg_rdata <= next_rdata;
		end else begin
			reg_rdata <= TSC_BYTE_ZERO;
		end
	end

	chk_masked_run_write: assert property (
		sw_touch |=> timer0_active_flag == $past(reg_wdata[TSC_CTRL_RUN_LSB]))
		else $error("timer0 run flag does not follow masked write");

	chk_unmasked_keeps_run: assert property (
		ctrl_wr && (reg_wdata[3:1] == 3'h0) && (other_timer_stopped == 3'h0)
		|=> other_active_flag == $past(other_active_flag))
		else $error("run flags changed without write enable");

	chk_ctrl_readback: assert property (
		reg_rd && (reg_addr == TSC_ADDR_CTRL)
		|=> reg_rdata == {$past(timer_running), 4'h0})
		else $error("control readback does not show running flags");

	chk_start_loads_reload: assert property (
		sw_start |=> timer0_active_flag && (timer0_count == $past(timer0_reload_word)))
		else $error("start did not load reload value");

	chk_rx_halt_stop: assert property (
		stop_rx && !sw_touch |=> !timer0_active_flag && irq_status[TSC_IRQ_RX_HALT])
		else $error("timer0 not halted after first received bits");

	chk_trim_ignores_rx: assert property (
		trim_mode && timer0_active_flag && rx_first_bits && !lfo_rise && !sw_touch && !stop_uf
		|=> timer0_active_flag)
		else $error("receive halt acted in trimming mode");

	chk_tx_autostart: assert property (
		!timer0_active_flag && tx_end && (cfg.timer0_start_mode == TSC_START_TX_END) && !sw_touch
		|=> timer0_active_flag && (timer0_count == $past(timer0_reload_word)))
		else $error("no automatic start at transmit end");

	chk_manual_no_start: assert property (
		!timer0_active_flag && (cfg.timer0_start_mode == TSC_START_MANUAL) && !sw_touch
		|=> !timer0_active_flag)
		else $error("timer0 started by itself in manual mode");

	chk_trim_no_underflow: assert property (
		(cfg.timer0_start_mode == TSC_START_TRIM_NO_UF) && timer0_active_flag && at_zero && tick_sel && !load_evt
		|=> (timer0_count == TSC_COUNT_RESET) && !timer0_underflow)
		else $error("underflow in trimming mode without underflow");

	chk_auto_restart: assert property (
		restart_uf && !sw_touch
		|=> timer0_active_flag && (timer0_count == $past(timer0_reload_word)))
		else $error("no reload after underflow with auto restart");

	chk_stop_at_zero: assert property (
		stop_uf && !sw_touch |=> !timer0_active_flag)
		else $error("timer0 kept running after underflow without restart");

	chk_underflow_flag: assert property (
		underflow_evt |=> irq_status[TSC_IRQ_UNDERFLOW] && timer0_underflow)
		else $error("underflow did not set interrupt flag");

	chk_underflow_pulse: assert property (
		!underflow_evt |=> !timer0_underflow)
		else $error("underflow pulse without underflow");

	chk_count_down: assert property (
		tick_active && !at_zero && !load_evt |=> timer0_count == $past(timer0_count) - 16'h0001)
		else $error("timer0 did not decrement on tick");

	chk_idle_count_hold: assert property (
		!timer0_active_flag && !load_evt |=> timer0_count == $past(timer0_count))
		else $error("stopped count changed without start");

	chk_cfg_reserved: assert property (
		reg_rd && (reg_addr == TSC_ADDR_CFG) |=> (reg_rdata[6] == 1'b0) && (reg_rdata[2] == 1'b0))
		else $error("reserved configuration bits read nonzero");

	chk_other_run_write: assert property (
		ctrl_wr |=> timer_running[3:1] == (($past(reg_wdata[7:5]) & $past(reg_wdata[3:1]))
			| ($past(timer_running[3:1]) & ~$past(reg_wdata[3:1]) & ~$past(other_timer_stopped))))
		else $error("other run flags do not follow masked write");

	chk_ff_starts_all: assert property (
		ctrl_wr && (reg_wdata == 8'hff) |=> timer_running == 4'hf)
		else $error("full write did not start all timers");

	chk_f0_changes_none: assert property (
		ctrl_wr && (reg_wdata == 8'hf0) && (other_timer_stopped == 3'h0) && !stop_evt && !start_evt
		|=> $stable(timer_running))
		else $error("write without enables changed run flags");

	chk_sw_wins: assert property (
		sw_start && stop_evt |=> timer0_active_flag)
		else $error("hardware stop overrode software start");

	chk_rx_needs_halt: assert property (
		timer0_active_flag && rx_first_bits && !cfg.timer0_halt_on_receive && !sw_touch && !stop_trim && !stop_uf
		|=> timer0_active_flag)
		else $error("receive stopped timer0 with halt bit clear");

	chk_trim_edge_start: assert property (
		!timer0_active_flag && trim_mode && lfo_rise && !sw_touch
		|=> timer0_active_flag && (timer0_count == $past(timer0_reload_word)))
		else $error("oscillator edge did not start timer0");

	chk_trim_edge_stop: assert property (
		timer0_active_flag && trim_mode && lfo_rise && !sw_touch |=> !timer0_active_flag)
		else $error("oscillator edge did not stop timer0");

	// An unselected source never moves the count
	chk_sel_fast_only: assert property (
		(cfg.timer0_clock_select == TSC_CLK_FAST) && !ticks.tick_fast && !load_evt
		|=> $stable(timer0_count))
		else $error("count moved without fast tick");

	chk_sel_slow_only: assert property (
		(cfg.timer0_clock_select == TSC_CLK_SLOW) && !ticks.tick_slow && !load_evt
		|=> $stable(timer0_count))
		else $error("count moved without slow tick");

	chk_sel_timer2_only: assert property (
		(cfg.timer0_clock_select == TSC_CLK_TIMER2) && !ticks.timer2_underflow && !load_evt
		|=> $stable(timer0_count))
		else $error("count moved without timer2 underflow");

	chk_sel_timer1_only: assert property (
		(cfg.timer0_clock_select == TSC_CLK_TIMER1) && !ticks.timer1_underflow && !load_evt
		|=> $stable(timer0_count))
		else $error("count moved without timer1 underflow");

	chk_reload_write_wait: assert property (
		reg_wr && ((reg_addr == TSC_ADDR_RELOAD_HI) || (reg_addr == TSC_ADDR_RELOAD_LO)) && !load_evt && !tick_active
		|=> $stable(timer0_count))
		else $error("reload write disturbed the count");

	chk_count_hi_read: assert property (
		reg_rd && (reg_addr == TSC_ADDR_COUNT_HI) |=> reg_rdata == $past(timer0_count[15:8]))
		else $error("count high byte read wrong");

	chk_count_lo_read: assert property (
		reg_rd && (reg_addr == TSC_ADDR_COUNT_LO) |=> reg_rdata == $past(timer0_count[7:0]))
		else $error("count low byte read wrong");

	chk_rdata_one_cycle: assert property (
		!reg_rd |=> reg_rdata == TSC_BYTE_ZERO)
		else $error("read data stood beyond its cycle");

	chk_enable_read: assert property (
		reg_rd && (reg_addr == TSC_ADDR_IRQ_ENABLE) |=> reg_rdata == {5'h00, $past(irq_enable)})
		else $error("interrupt enable read wrong");

	chk_status_sticky: assert property (
		irq_status[TSC_IRQ_UNDERFLOW] && !(reg_wr && (reg_addr == TSC_ADDR_IRQ_CLEAR) && reg_wdata[TSC_IRQ_UNDERFLOW])
		|=> irq_status[TSC_IRQ_UNDERFLOW])
		else $error("underflow status lost without clear");

	chk_stop_status: assert property (
		stop_uf && !sw_touch |=> irq_status[TSC_IRQ_STOPPED])
		else $error("hardware stop did not set status");

	chk_irq_level: assert property (
		1'b1 |=> irq == |(irq_status & $past(irq_enable)))
		else $error("interrupt output does not follow enabled status");
endmodule : tsc_timer_section
`default_nettype wire

// *** tsc_timer_section_tb_top.sv ***
`timescale 1ns/10ps
`default_nettype none
module tsc_timer_section_tb_top
	import tsc_pkg::*;
;
	logic clk;
	logic rst_n;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
	logic reg_wr, reg_rd, tx_end, rx_first_bits, low_freq_oscillator, timer0_underflow, irq;
	tsc_ticks_type ticks;
	logic [3:1] other_timer_stopped;
	logic [3:0] timer_running, exp_run;
	logic [15:0] c;
	int errors, cmp_count;

	tsc_timer_section uut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .ticks(ticks), .tx_end(tx_end), .rx_first_bits(rx_first_bits),
		.low_freq_oscillator(low_freq_oscillator), .other_timer_stopped(other_timer_stopped),
		.timer_running(timer_running), .timer0_underflow(timer0_underflow), .irq(irq));

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	task automatic close_out();
		$display("comparisons %0d mismatches %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : close_out

	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
		cmp_count++;
		if (g !== e) begin
			errors++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [7:0] dv);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= dv;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
		#1;
	endtask : wr

	// Read data stand only in the cycle after the strobe, so sample there
	task automatic rd(input logic [7:0] a, output logic [7:0] r);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		r = reg_rdata;
	endtask : rd

	task automatic rdchk(input string n, input logic [7:0] a, input logic [7:0] e);
		logic [7:0] r;
		rd(a, r);
		chk(n, {8'h00, e}, {8'h00, r});
	endtask : rdchk

	// High and low bytes are separate reads, so no ticks may fall between them
	task automatic rdcnt(output logic [15:0] r);
		logic [7:0] h;
		logic [7:0] l;
		rd(TSC_ADDR_COUNT_HI, h);
		rd(TSC_ADDR_COUNT_LO, l);
		r = {h, l};
	endtask : rdcnt

	task automatic tick(input tsc_ticks_type t);
		@(posedge clk);
		ticks <= t;
		@(posedge clk);
		ticks <= '0;
		#1;
	endtask : tick

	task automatic ev(input logic tx, input logic rx);
		@(posedge clk);
		tx_end <= tx;
		rx_first_bits <= rx;
		@(posedge clk);
		tx_end <= 1'b0;
		rx_first_bits <= 1'b0;
		#1;
	endtask : ev

	task automatic wait_run(input logic e);
		for (int i = 0; i < 10 && timer_running[0] !== e; i++) begin
			@(posedge clk);
			#1;
		end
		chk("timer0 running after wait", {15'h0000, e}, {15'h0000, timer_running[0]});
		if (timer_running[0] !== e) close_out();
	endtask : wait_run

	function automatic logic [7:0] cfg(input logic h, input logic [1:0] m, input logic rs, input logic [1:0] s);
		return {h, 1'b0, m, rs, 1'b0, s};
	endfunction : cfg

	function automatic tsc_ticks_type sel_tick(input logic [1:0] s);
		return s == 2'h0 ? 4'h8 : s == 2'h1 ? 4'h4 : s == 2'h2 ? 4'h1 : 4'h2;
	endfunction : sel_tick

	function automatic logic [3:0] ctrl_next(input logic [3:0] run, input logic [7:0] dv);
		return (run & ~dv[3:0]) | (dv[7:4] & dv[3:0]);
	endfunction : ctrl_next

	initial begin
		rst_n = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		ticks = '0;
		tx_end = 1'b0;
		rx_first_bits = 1'b0;
		low_freq_oscillator = 1'b0;
		other_timer_stopped = 3'h0;
		errors = 0;
		cmp_count = 0;
		void'($urandom(60));
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		for (int i = 0; i < 6; i++) rdchk("reset register", TSC_ADDR_CTRL + 8'(i), 8'h00);
		rdchk("reset irq enable", TSC_ADDR_IRQ_ENABLE, 8'h00);
		rdchk("unmapped read", 8'h55, 8'h00);
		$display("test reset done");
		for (int i = 0; i < 6; i++) begin
			d = 8'($urandom);
			wr(TSC_ADDR_CFG, d);
			rdchk("config readback", TSC_ADDR_CFG, d & 8'hbb);
		end
		wr(TSC_ADDR_CFG, 8'h00);
		wr(TSC_ADDR_RELOAD_HI, 8'h80);
		exp_run = 4'h0;
		for (int i = 0; i < 12; i++) begin
			d = i == 0 ? 8'hff : i == 1 ? 8'hf0 : 8'($urandom);
			wr(TSC_ADDR_CTRL, d);
			exp_run = ctrl_next(exp_run, d);
			chk("running flags", {12'h000, exp_run}, {12'h000, timer_running});
			rdchk("control readback", TSC_ADDR_CTRL, {exp_run, 4'h0});
		end
		wr(TSC_ADDR_CTRL, 8'hee);
		@(posedge clk);
		other_timer_stopped <= 3'h5;
		@(posedge clk);
		other_timer_stopped <= 3'h0;
		#1;
		chk("other timers stopped", 16'h0004, {12'h000, timer_running[3:1], 1'b0});
		$display("test control mask done");
		wr(TSC_ADDR_CTRL, 8'h0f);
		wr(TSC_ADDR_RELOAD_HI, 8'h12);
		wr(TSC_ADDR_RELOAD_LO, 8'h34);
		wr(TSC_ADDR_CTRL, 8'h11);
		rdcnt(c);
		chk("count at start", 16'h1234, c);
		wr(TSC_ADDR_RELOAD_HI, 8'h00);
		wr(TSC_ADDR_RELOAD_LO, 8'h03);
		rdcnt(c);
		chk("count after reload write", 16'h1234, c);
		for (int s = 0; s < 4; s++) begin
			wr(TSC_ADDR_CFG, cfg(1'b0, 2'h0, 1'b0, 2'(s)));
			wr(TSC_ADDR_CTRL, 8'h11);
			for (int k = 0; k < 4; k++) tick(4'(1 << k));
			rdcnt(c);
			chk("count one selected tick", 16'h0002, c);
		end
		$display("test count and clock select done");
		wr(TSC_ADDR_IRQ_ENABLE, 8'h07);
		rdchk("irq enable readback", TSC_ADDR_IRQ_ENABLE, 8'h07);
		wr(TSC_ADDR_RELOAD_LO, 8'h02);
		wr(TSC_ADDR_CFG, cfg(1'b0, 2'h0, 1'b0, 2'h0));
		wr(TSC_ADDR_CTRL, 8'h11);
		repeat (3) tick(sel_tick(2'h0));
		chk("underflow pulse", 16'h0001, {15'h0000, timer0_underflow});
		chk("stopped at zero", 16'h0000, {15'h0000, timer_running[0]});
		rdchk("irq status", TSC_ADDR_IRQ_STATUS, 8'h05);
		chk("irq raised", 16'h0001, {15'h0000, irq});
		wr(TSC_ADDR_IRQ_ENABLE, 8'h00);
		@(posedge clk);
		#1;
		chk("irq masked", 16'h0000, {15'h0000, irq});
		wr(TSC_ADDR_IRQ_ENABLE, 8'h01);
		wr(TSC_ADDR_IRQ_CLEAR, 8'h07);
		@(posedge clk);
		#1;
		chk("irq cleared", 16'h0000, {15'h0000, irq});
		rdchk("status cleared", TSC_ADDR_IRQ_STATUS, 8'h00);
		wr(TSC_ADDR_CFG, cfg(1'b0, 2'h0, 1'b1, 2'h0));
		wr(TSC_ADDR_CTRL, 8'h11);
		repeat (3) tick(sel_tick(2'h0));
		chk("restart underflow", 16'h0001, {15'h0000, timer0_underflow});
		chk("restart running", 16'h0001, {15'h0000, timer_running[0]});
		rdcnt(c);
		chk("restart count", 16'h0002, c);
		$display("test underflow done");
		wr(TSC_ADDR_CTRL, 8'h01);
		wr(TSC_ADDR_CFG, cfg(1'b0, 2'h0, 1'b0, 2'h0));
		ev(1'b1, 1'b0);
		chk("no auto start", 16'h0000, {15'h0000, timer_running[0]});
		wr(TSC_ADDR_CFG, cfg(1'b0, 2'h1, 1'b0, 2'h0));
		ev(1'b1, 1'b0);
		chk("start at tx end", 16'h0001, {15'h0000, timer_running[0]});
		ev(1'b0, 1'b1);
		chk("no halt when clear", 16'h0001, {15'h0000, timer_running[0]});
		wr(TSC_ADDR_CFG, cfg(1'b1, 2'h0, 1'b0, 2'h0));
		ev(1'b0, 1'b1);
		chk("halt on receive", 16'h0000, {15'h0000, timer_running[0]});
		wr(TSC_ADDR_CFG, cfg(1'b1, 2'h2, 1'b0, 2'h0));
		wr(TSC_ADDR_CTRL, 8'h11);
		ev(1'b0, 1'b1);
		chk("halt ignored trimming", 16'h0001, {15'h0000, timer_running[0]});
		$display("test events done");
		@(posedge clk);
		low_freq_oscillator <= 1'b1;
		wait_run(1'b0);
		low_freq_oscillator <= 1'b0;
		repeat (4) @(posedge clk);
		low_freq_oscillator <= 1'b1;
		wait_run(1'b1);
		repeat (3) tick(sel_tick(2'h0));
		chk("trim parks at zero", 16'h0000, {15'h0000, timer0_underflow});
		rdcnt(c);
		chk("trim count parked", 16'h0000, c);
		wr(TSC_ADDR_CFG, cfg(1'b0, 2'h3, 1'b0, 2'h0));
		tick(sel_tick(2'h0));
		chk("trim underflow", 16'h0001, {15'h0000, timer0_underflow});
		$display("test trimming done");
		close_out();
	end
endmodule : tsc_timer_section_tb_top
`default_nettype wire
